// ==== logic/mmu_regs_params.svh ====
// Purpose: Offsets-free constants for the translation register set
// Assumes: Register selection is by select code, not by address
// Notes: Field positions follow the register layouts
`ifndef MMU_REGS_PARAMS_SVH
`define MMU_REGS_PARAMS_SVH

`define TC_ENABLE 31
`define TC_SRS 25
`define TC_FCL 24
`define TC_PS_HI 23
`define TC_PS_LO 20
`define TC_PS_MUST 23
`define TC_IS_HI 19
`define TC_IS_LO 16
`define TC_IMPL_MASK 32'h83ff_ffff
`define TC_RESET 32'h0000_0000
`define TC_TOTAL 7'h20
`define CS_FLUSH 15
`define CS_LOCKW 14
`define CS_RESET 16'h0000
`define LVL_RESET 3'h0
`define SCC_RESET 8'h00
`define LVL_LSB 5

`endif

// ==== logic/mmu_regs_pkg.sv ====
// Purpose: Shared types for the translation register set
// Assumes: Nothing beyond the params header
// Notes: Host request travels as one packed struct
package mmu_regs_pkg;
    typedef enum logic [2:0] {SEL_CS, SEL_TC, SEL_CAL, SEL_VAL, SEL_SCC} reg_sel_t;
    typedef enum logic [1:0] {ROOT_USER, ROOT_SUPER, ROOT_DMA} root_t;
    typedef struct packed {
        logic wr;
        logic rd;
        reg_sel_t sel;
        logic [31:0] data;
    } cop_req_t;
    typedef struct packed {
        logic [31:0] tc;
        logic [15:0] cs;
        logic [2:0] cal;
        logic [2:0] val;
        logic [7:0] stack_switch_mask;
        logic [31:0] rdata;
        logic cfg_exc;
        logic instr_exc;
        logic flush_all;
        logic [31:0] phys_addr;
        logic phys_strobe;
        logic cpu_strobe;
        root_t root_sel;
        logic [14:0] first_index;
        logic fc_index;
        logic [2:0] depth;
        logic [31:0] page_mask;
        logic lock_inhibit;
        logic abort;
        logic stack_switch;
    } state_t;
endpackage : mmu_regs_pkg

// ==== logic/walk_index.sv ====
// Purpose: First-level table index and search shape from the control word
// Assumes: Purely combinational, registered by the caller
// Notes: Index widths above 15 are impossible by field size
module walk_index (
    input wire logic [31:0] addr,
    input wire logic [31:0] tc,
    input wire logic [3:0] fc,
    input wire logic use_dma,
    output logic [14:0] first_index,
    output logic fc_index,
    output logic [2:0] depth,
    output logic [31:0] page_mask
);
    `include "mmu_regs_params.svh"
    logic [3:0] ish;
    logic [3:0] ps;
    logic [3:0] level_a_index_bits;
    logic [31:0] shifted;

    always_comb begin
        ish = tc[`TC_IS_HI:`TC_IS_LO];
        ps = tc[`TC_PS_HI:`TC_PS_LO];
        level_a_index_bits = tc[15:12];
        // Top bits dropped for walking only, matching still sees them
        shifted = addr << ish; // [RQ18]
        fc_index = tc[`TC_FCL] | use_dma; // [RQ14]
        if (fc_index) begin
            first_index = {11'h000, fc}; // [RQ14]
        end else if (level_a_index_bits == 4'h0) begin
            first_index = 15'h0000; // [RQ19]
        end else begin
            first_index = 15'(shifted >> (6'h20 - {2'h0, level_a_index_bits})); // [RQ15]
        end
        // Search stops at the first zero width
        if (level_a_index_bits == 4'h0) begin
            depth = 3'h0; // [RQ19]
        end else if (tc[11:8] == 4'h0) begin
            depth = 3'h1;
        end else if (tc[7:4] == 4'h0) begin
            depth = 3'h2;
        end else if (tc[3:0] == 4'h0) begin
            depth = 3'h3;
        end else begin
            depth = 3'h4;
        end
        page_mask = (32'h1 << ps) - 32'h1; // [RQ16]
    end
endmodule : walk_index

// ==== logic/mmu_config_status_regs.sv ====
// Purpose: Control and status registers of a paged translation unit
// Assumes: Host moves/restores arrive as one-cycle requests on cop
// Notes: Table walker and cache feed results in through plain ports
//
// How it works
// RQ1 - Root pointer write refreshes cache status
// RQ2 - Status low bits show current alias
// RQ3 - Flush flag mirrors alias flush on write
// RQ4 - Software purges logical cache when flushed
// RQ5 - Lock warning at all-but-one locked
// RQ6 - Unimplemented control bits read zero
// RQ7 - Write with enable clear flushes cache
// RQ8 - Enabled write checks field sum equals 32
// RQ9 - Failed check stores value, enable cleared
// RQ10 - Disabled: probe, preload, call trap
// RQ11 - Disabled: addresses pass, strobes direct
// RQ12 - Reset clears enable; set only from clear
// RQ13 - Supervisor root select picks root
// RQ14 - Function code indexes top table
// RQ15 - Else index from shift and width
// RQ16 - Page size code gives size
// RQ17 - Page size bit three zero traps
// RQ18 - Initial shift drops top bits
// RQ19 - Level widths; zero ends search
// RQ20 - Level registers keep upper three bits
// RQ21 - Level check aborts violating cycle
// RQ22 - Call copies level; both host-loadable
// RQ23 - Stack switch from mask range
module mmu_config_status_regs #(
    parameter int unsigned CACHE_ENTRIES = 64
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input mmu_regs_pkg::cop_req_t cop,
    output logic [31:0] rdata,
    input wire logic urp_write,
    input wire logic [2:0] rpt_alias,
    input wire logic rpt_flushed,
    input wire logic [7:0] locked_count,
    input wire logic instr_req,
    input wire logic mod_call,
    input wire logic mod_return,
    input wire logic [2:0] target_level,
    input wire logic acc_valid,
    input wire logic cpu_space,
    input wire logic dev_space,
    input wire logic supervisor,
    input wire logic [3:0] fc,
    input wire logic [1:0] alc,
    input wire logic [31:0] logical_addr,
    input wire logic [31:0] xlat_addr,
    input wire logic xlat_hit,
    output logic [31:0] tc_out,
    output logic [15:0] cs_out,
    output logic cfg_exc,
    output logic instr_exc,
    output logic flush_all,
    output logic [31:0] phys_addr,
    output logic physical_strobe,
    output logic cpu_space_strobe,
    output mmu_regs_pkg::root_t root_sel,
    output logic [14:0] first_index,
    output logic fc_index,
    output logic [2:0] search_depth,
    output logic [31:0] page_mask,
    output logic lock_inhibit,
    output logic abort,
    output logic stack_switch
);
    import mmu_regs_pkg::*;
    `include "mmu_regs_params.svh"

    logic [1:0] rst_sync_reg;
    logic rst_n;
    state_t st_reg;
    state_t st_next;
    logic [14:0] idx_w;
    logic fci_w;
    logic [2:0] depth_w;
    logic [31:0] pmask_w;
    logic [31:0] tc_w;
    logic tc_bad;
    logic tc_wr;

    function automatic logic [6:0] field_sum(input logic [31:0] v);
        field_sum = 7'(v[23:20]) + 7'(v[19:16]) + 7'(v[15:12]) + 7'(v[11:8])
            + 7'(v[7:4]) + 7'(v[3:0]);
    endfunction : field_sum

    function automatic logic need_switch(input logic [7:0] mask, input logic [2:0] n,
                                         input logic [2:0] m);
        need_switch = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (m < n && i >= m && i <= n && mask[i]) begin
                need_switch = 1'b1;
            end
        end
    endfunction : need_switch

    function automatic logic [2:0] lvl_mask(input logic [1:0] bits);
        // Upper level bits only; zero bits means no check
        lvl_mask = ~(3'h7 >> bits);
    endfunction : lvl_mask

    // Reset enters asynchronously, leaves synchronously
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    walk_index u_walk (
        .addr(logical_addr),
        .tc(st_reg.tc),
        .fc(fc),
        .use_dma(fc[3]),
        .first_index(idx_w),
        .fc_index(fci_w),
        .depth(depth_w),
        .page_mask(pmask_w)
    );

    always_comb begin
        tc_wr = cop.wr && cop.sel == SEL_TC;
        tc_w = cop.data & `TC_IMPL_MASK; // [RQ6]
        tc_bad = !tc_w[`TC_PS_MUST] // [RQ17]
            || (tc_w[`TC_ENABLE] && field_sum(tc_w) != `TC_TOTAL); // [RQ8]
    end

    always_comb begin
        st_next = st_reg;
        st_next.cfg_exc = 1'b0;
        st_next.instr_exc = 1'b0;
        st_next.flush_all = 1'b0;
        st_next.stack_switch = 1'b0;
        st_next.abort = 1'b0;
        st_next.phys_strobe = 1'b0;
        st_next.cpu_strobe = 1'b0;
        // Alias and flush come from the root pointer table search
        if (urp_write) begin
            st_next.cs[2:0] = rpt_alias; // [RQ1] [RQ2]
            st_next.cs[`CS_FLUSH] = rpt_flushed; // [RQ3]
        end
        st_next.cs[`CS_LOCKW] = 32'(locked_count) >= CACHE_ENTRIES - 1; // [RQ5]
        st_next.lock_inhibit = st_next.cs[`CS_LOCKW]; // [RQ5]
        // Refused: a set while already enabled leaves everything alone
        if (tc_wr && !(tc_w[`TC_ENABLE] && st_reg.tc[`TC_ENABLE])) begin // [RQ12]
            st_next.tc = tc_w;
            st_next.flush_all = !tc_w[`TC_ENABLE]; // [RQ7]
            if (tc_bad) begin
                st_next.tc[`TC_ENABLE] = 1'b0; // [RQ9]
                st_next.cfg_exc = 1'b1; // [RQ8]
            end
        end
        st_next.instr_exc = instr_req && !st_reg.tc[`TC_ENABLE]; // [RQ10]
        if (mod_call) begin
            st_next.val = st_reg.cal; // [RQ22]
            st_next.cal = target_level;
            st_next.stack_switch = need_switch(st_reg.stack_switch_mask, st_reg.cal, target_level); // [RQ23]
        end else if (mod_return) begin
            st_next.cal = target_level;
        end
        // Host loads land after call updates so software has the last word
        if (cop.wr && cop.sel == SEL_CAL) begin
            st_next.cal = cop.data[7:`LVL_LSB]; // [RQ20] [RQ22]
        end
        if (cop.wr && cop.sel == SEL_VAL) begin
            st_next.val = cop.data[7:`LVL_LSB]; // [RQ20] [RQ22]
        end
        if (cop.wr && cop.sel == SEL_SCC) begin
            st_next.stack_switch_mask = cop.data[7:0];
        end
        if (cop.rd) begin
            unique case (cop.sel)
                SEL_CS: st_next.rdata = {16'h0000, st_reg.cs};
                SEL_TC: st_next.rdata = st_reg.tc; // [RQ6]
                SEL_CAL: st_next.rdata = {24'h0, st_reg.cal, 5'h00}; // [RQ20]
                SEL_VAL: st_next.rdata = {24'h0, st_reg.val, 5'h00}; // [RQ20]
                SEL_SCC: st_next.rdata = {24'h0, st_reg.stack_switch_mask};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        // Root choice: function code bit three marks another bus master
        if (fc[3]) begin
            st_next.root_sel = ROOT_DMA;
        end else if (supervisor && st_reg.tc[`TC_SRS]) begin
            st_next.root_sel = ROOT_SUPER; // [RQ13]
        end else begin
            st_next.root_sel = ROOT_USER; // [RQ13]
        end
        st_next.first_index = idx_w; // [RQ15]
        st_next.fc_index = fci_w; // [RQ14]
        st_next.depth = depth_w; // [RQ19]
        st_next.page_mask = pmask_w; // [RQ16]
        if (acc_valid) begin
            if (!st_reg.tc[`TC_ENABLE]) begin
                st_next.phys_addr = logical_addr; // [RQ11]
                st_next.phys_strobe = !cpu_space; // [RQ11]
                st_next.cpu_strobe = cpu_space && !dev_space; // [RQ11]
            end else begin
                st_next.phys_addr = xlat_addr;
                st_next.phys_strobe = !cpu_space && xlat_hit;
                st_next.cpu_strobe = cpu_space && !dev_space;
            end
            // Lower level code means more privilege
            if (alc != 2'h0 && !supervisor && (logical_addr[31:29] & lvl_mask(alc))
                    < (st_reg.cal & lvl_mask(alc))) begin
                st_next.abort = 1'b1; // [RQ21]
                st_next.phys_strobe = 1'b0; // [RQ21]
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.tc <= `TC_RESET; // [RQ12]
            st_reg.cs <= `CS_RESET;
            st_reg.cal <= `LVL_RESET;
            st_reg.val <= `LVL_RESET;
            st_reg.stack_switch_mask <= `SCC_RESET;
            st_reg.root_sel <= ROOT_USER;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign tc_out = st_reg.tc;
    assign cs_out = st_reg.cs;
    assign cfg_exc = st_reg.cfg_exc;
    assign instr_exc = st_reg.instr_exc;
    assign flush_all = st_reg.flush_all;
    assign phys_addr = st_reg.phys_addr;
    assign physical_strobe = st_reg.phys_strobe;
    assign cpu_space_strobe = st_reg.cpu_strobe;
    assign root_sel = st_reg.root_sel;
    assign first_index = st_reg.first_index;
    assign fc_index = st_reg.fc_index;
    assign search_depth = st_reg.depth;
    assign page_mask = st_reg.page_mask;
    assign lock_inhibit = st_reg.lock_inhibit;
    assign abort = st_reg.abort;
    assign stack_switch = st_reg.stack_switch;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_FLUSH_ON_CLEAR: assert property ( // [RQ7]
        tc_wr && !cop.data[`TC_ENABLE] |=> flush_all && !tc_out[`TC_ENABLE])
        else $error("No flush after disabling write");
    AST_CFG_EXC: assert property ( // [RQ8]
        tc_wr && !tc_out[`TC_ENABLE] && tc_bad |=> cfg_exc && !tc_out[`TC_ENABLE]
            && tc_out[23:0] == $past(cop.data[23:0]))
        else $error("Bad config not trapped or not stored");
    AST_SET_WHILE_SET: assert property ( // [RQ12]
        tc_wr && cop.data[`TC_ENABLE] && tc_out[`TC_ENABLE] |=> $stable(tc_out) && !cfg_exc)
        else $error("Control changed while enabled");
    AST_INSTR_TRAP: assert property ( // [RQ10]
        instr_req |=> instr_exc == !$past(tc_out[`TC_ENABLE]))
        else $error("Instruction trap mismatch");
    AST_PASS_THROUGH: assert property ( // [RQ11]
        acc_valid && !tc_out[`TC_ENABLE] && !cpu_space && alc == 2'h0
            |=> physical_strobe && phys_addr == $past(logical_addr))
        else $error("Disabled access not passed through");
    AST_ALIAS_UPDATE: assert property ( // [RQ1]
        urp_write |=> cs_out[2:0] == $past(rpt_alias) && cs_out[15] == $past(rpt_flushed)
            ##1 cs_out[2:0] == $past(cs_out[2:0]) || $past(urp_write))
        else $error("Cache status not refreshed");
    AST_CALL_COPY: assert property ( // [RQ22]
        mod_call && !(cop.wr && cop.sel == SEL_VAL) |=> st_reg.val == $past(st_reg.cal))
        else $error("Caller level not copied");
    AST_LEVEL_READ: assert property ( // [RQ20]
        cop.rd && (cop.sel == SEL_CAL || cop.sel == SEL_VAL) |=> rdata[4:0] == 5'h00
            && rdata[31:8] == 24'h0)
        else $error("Level read shows unimplemented bits");
    AST_STACK_SWITCH: assert property ( // [RQ23]
        mod_call && target_level >= st_reg.cal |=> !stack_switch)
        else $error("Stack switch without privilege gain");
    AST_LOCK_WARN: assert property ( // [RQ5]
        32'(locked_count) >= CACHE_ENTRIES - 1 |=> cs_out[14] && lock_inhibit)
        else $error("Lock warning missing");
    // Full three-bit level field, user cycle below current level
    AST_ABORT_LEVEL: assert property ( // [RQ21]
        acc_valid && alc == 2'h3 && !supervisor && logical_addr[31:29] < st_reg.cal
            |=> abort && !physical_strobe)
        else $error("Level violation not aborted");
    AST_NO_ABORT_SUPER: assert property ( // [RQ21]
        acc_valid && supervisor |=> !abort)
        else $error("Supervisor cycle aborted");
    AST_RETURN_LOAD: assert property ( // [RQ22]
        mod_return && !mod_call && !(cop.wr && cop.sel == SEL_CAL)
            |=> st_reg.cal == $past(target_level))
        else $error("Return did not load level");
    AST_PAGE_MASK: assert property ( // [RQ16]
        tc_out[23:20] == 4'h8 |=> page_mask == 32'h0000_00ff)
        else $error("Smallest page mask wrong");
    AST_DEPTH_STOP: assert property ( // [RQ19]
        tc_out[15:12] == 4'h0 |=> search_depth == 3'h0)
        else $error("Search not stopped at zero width");
endmodule : mmu_config_status_regs

// ==== tb/host_model.sv ====
// Purpose: Host processor side issuing register moves and restores
// Assumes: Every call begins just after a rising clock edge
// Notes: Released data is inverted so a stale bus never looks valid
module host_model (
    input wire logic core_clk,
    output mmu_regs_pkg::cop_req_t cop,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import mmu_regs_pkg::*;

    initial cop = '0;

    // Request held across one taking edge; caller must idle a cycle after
    task automatic access(input logic w, input reg_sel_t s, input logic [31:0] d,
                          output logic [31:0] q);
        cop.wr = w;
        cop.rd = !w;
        cop.sel = s;
        cop.data = d;
        @(posedge core_clk);
        #1;
        q = rdata;
        cop.wr = 1'b0;
        cop.rd = 1'b0;
        cop.data = ~d;
    endtask : access
endmodule : host_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the translation register set
// Assumes: Inputs change 1 ns after rising edges
// Notes: Address translation proper is not modelled, only its controls
`include "mmu_regs_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mmu_regs_pkg::*;

    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    cop_req_t cop;
    logic [31:0] rdata, tc_out, phys_addr, page_mask, q, t;
    logic [31:0] logical_addr = 32'h0, xlat_addr = 32'h0;
    logic [15:0] cs_out;
    logic [14:0] first_index;
    logic [7:0] locked_count = 8'h00, m;
    logic [3:0] fc = 4'h5;
    logic [2:0] rpt_alias = 3'h0, target_level = 3'h0, search_depth, c, g;
    logic [1:0] alc = 2'h0;
    logic urp_write = 1'b0, rpt_flushed = 1'b0, instr_req = 1'b0, mod_call = 1'b0;
    logic mod_return = 1'b0, acc_valid = 1'b0, cpu_space = 1'b0, dev_space = 1'b0;
    logic supervisor = 1'b1, xlat_hit = 1'b0, ce, fa;
    logic cfg_exc, instr_exc, flush_all, physical_strobe, cpu_space_strobe, fc_index;
    logic lock_inhibit, abort, stack_switch;
    root_t root_sel;
    int err_total = 0, comparisons = 0, cycles = 0, seed = 32'h986f, s;

    mmu_config_status_regs #(.CACHE_ENTRIES(64)) DUT (.*);
    host_model host (.core_clk(core_clk), .cop(cop), .rdata(rdata));

    always #10 core_clk = ~core_clk;

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, v);
        end
    endtask : chk

    // Pulses are caught before the idle cycle that keeps requests apart
    task automatic wr(input reg_sel_t sl, input logic [31:0] d);
        host.access(1'b1, sl, d, q);
        ce = cfg_exc;
        fa = flush_all;
        step();
    endtask : wr

    task automatic rd(input reg_sel_t sl);
        host.access(1'b0, sl, 32'h0, q);
        step();
    endtask : rd

    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    function automatic logic exp_cfg(input logic [31:0] v);
        logic [6:0] sum;
        sum = 7'(v[23:20]) + 7'(v[19:16]) + 7'(v[15:12]) + 7'(v[11:8]) + 7'(v[7:4])
            + 7'(v[3:0]);
        return (v[31] && sum != `TC_TOTAL) || !v[23];
    endfunction : exp_cfg

    function automatic logic exp_sw(input logic [2:0] n, input logic [2:0] tg,
                                    input logic [7:0] mk);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (k >= tg && k <= n && mk[k]) hit = 1'b1;
        end
        return tg < n && hit;
    endfunction : exp_sw

    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        rd(SEL_TC);
        chk("tc reset", `TC_RESET, q);
        chk("cs reset", 32'(`CS_RESET), 32'(cs_out));
        $display("test reset done");
        wr(SEL_TC, 32'h80c0_aa00);
        chk("tc enable", 32'h80c0_aa00, tc_out);
        chk("cfg clean", 32'h0, 32'(ce));
        wr(SEL_TC, 32'h80d0_aa80);
        chk("tc locked", 32'h80c0_aa00, tc_out);
        wr(SEL_TC, 32'h7c80_0000);
        chk("flush", 32'h1, 32'(fa));
        rd(SEL_TC);
        chk("tc unimpl", 32'h0080_0000, q);
        wr(SEL_TC, 32'h0070_0000);
        chk("ps bit3", 32'h1, 32'(ce));
        chk("tc kept", 32'h0070_0000, tc_out);
        $display("test fixed control done");
        for (int i = 0; i < 12; i++) begin
            t = ($random(seed) & `TC_IMPL_MASK) | 32'h8000_0000;
            if (i[0]) begin
                t[23] = 1'b1;
                t[15:0] = t[15:0] & 16'h7777;
                s = 32 - t[23:20] - t[15:12] - t[11:8] - t[7:4] - t[3:0];
                if (s >= 0 && s < 16) t[19:16] = 4'(s);
            end
            wr(SEL_TC, t);
            chk("tc store", exp_cfg(t) ? t & 32'h7fff_ffff : t, tc_out);
            chk("cfg", 32'(exp_cfg(t)), 32'(ce));
            instr_req = 1'b1;
            step();
            instr_req = 1'b0;
            chk("instr", 32'(exp_cfg(t)), 32'(instr_exc));
            chk("root", 32'(t[25] ? ROOT_SUPER : ROOT_USER), 32'(root_sel));
            chk("fc index", 32'(t[24]), 32'(fc_index));
            wr(SEL_TC, 32'h0080_0000);
            chk("flush", 32'h1, 32'(fa));
        end
        $display("test random control done");
        for (int i = 0; i < 8; i++) begin
            {c, g, m} = 14'($random(seed));
            if (i < 2) begin
                c = 3'h5;
                g = 3'h1;
                m = i ? 8'hc1 : 8'h22;
            end
            wr(SEL_SCC, {24'h0, m});
            wr(SEL_CAL, {24'h0, c, 5'h1f});
            rd(SEL_CAL);
            chk("cal", {24'h0, c, 5'h0}, q);
            target_level = g;
            mod_call = 1'b1;
            step();
            mod_call = 1'b0;
            chk("stack", 32'(exp_sw(c, g, m)), 32'(stack_switch));
            rd(SEL_VAL);
            chk("val", {24'h0, c, 5'h0}, q);
            rd(SEL_CAL);
            chk("cal call", {24'h0, g, 5'h0}, q);
        end
        $display("test levels done");
        for (int i = 0; i < 6; i++) begin
            {rpt_alias, rpt_flushed} = 4'($random(seed));
            locked_count = 8'(61 + i);
            urp_write = 1'b1;
            step();
            urp_write = 1'b0;
            step();
            t = {16'h0, rpt_flushed, locked_count >= 8'h3f, 11'h0, rpt_alias};
            chk("status", t, 32'(cs_out));
            rd(SEL_CS);
            chk("status read", t, q);
        end
        $display("test status done");
        for (int i = 0; i < 8; i++) begin
            {cpu_space, dev_space, supervisor, fc} = 7'($random(seed));
            logical_addr = $random(seed);
            acc_valid = 1'b1;
            step();
            acc_valid = 1'b0;
            chk("phys addr", logical_addr, phys_addr);
            chk("strobes", {30'h0, !cpu_space, cpu_space && !dev_space},
                {30'h0, physical_strobe, cpu_space_strobe});
        end
        $display("test bypass done");
        alc = 2'h3;
        supervisor = 1'b0;
        cpu_space = 1'b0;
        fc = 4'h1;
        wr(SEL_CAL, 32'h0000_0080);
        wr(SEL_TC, 32'h0080_8000);
        for (int i = 0; i < 8; i++) begin
            logical_addr = $random(seed);
            acc_valid = 1'b1;
            step();
            acc_valid = 1'b0;
            chk("abort", 32'(logical_addr[31:29] < 3'h4), 32'(abort));
            chk("strobe", 32'(logical_addr[31:29] >= 3'h4), 32'(physical_strobe));
            chk("index", {24'h0, logical_addr[31:24]}, 32'(first_index));
            chk("depth", 32'h1, 32'(search_depth));
            chk("page mask", 32'h0000_00ff, page_mask);
        end
        $display("test level check done");
        results();
    end
endmodule : tb_top
